// ### rtl/mbw_write_slave.sv
// Slave end: checks write requests, updates coils and holding registers, answers.
//
// Summary of operation
// - Code 05 carries coil address, force value.
// - FF00 sets coil, 0000 clears it.
// - Single coil force answered by echo.
// - Code 06 carries register address, value.
// - Single register preset answered by echo.
// - Code 0F carries start, count, bytes, data.
// - Eight coils per byte, count rounded up.
// - Multi coil answer: header, count, CRC.
// - Code 10 carries start, count, bytes, words.
// - Byte count doubles count; words ascend.
// - Multi register answer: header, count, CRC.
// - Wire address zero is first element.
// - Coil bits and register words are writable.
`timescale 1ns/1ns
`default_nettype none
`include "mbw_params.svh"
module mbw_write_slave
  import mbw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  mbw_link_if.dev link,
  input wire logic [7:0] own_addr,
  output logic [`MBW_NCOIL-1:0] coil_area,
  output logic [`MBW_NREG*16-1:0] holding_register_area,
  output logic wr_done
);

  // ==========================================================
  // State
  typedef struct packed {
    mbw_dev_st_type st;
    logic [7:0] idx;
    logic ovf;
    logic [15:0] crc;
    logic [`MBW_FB_BYTES-1:0][7:0] fb;
    logic [7:0] k;
    logic [3:0] tidx;
    logic [`MBW_NCOIL-1:0] coil;
    logic [`MBW_NREG-1:0][15:0] hreg;
    logic done;
  } mbw_dev_state_type;

  mbw_dev_state_type q;
  mbw_dev_state_type d;

  logic [7:0] func;
  logic [15:0] addr_f;
  logic [15:0] val_f;
  logic [7:0] bc_f;
  logic [15:0] need_bc;
  logic len_ok;
  logic frame_ok;
  logic [15:0] elem;
  logic [7:0] bi;
  logic [7:0] bj;
  logic apply_last;

  // ==========================================================
  // Field decode of the stored request
  assign func = q.fb[`MBW_POS_FUNC];
  assign addr_f = {q.fb[`MBW_POS_AHI], q.fb[`MBW_POS_ALO]};
  assign val_f = {q.fb[`MBW_POS_VHI], q.fb[`MBW_POS_VLO]};
  assign bc_f = q.fb[`MBW_POS_BC];
  assign elem = addr_f + {8'h00, q.k};
  assign apply_last = ({8'h00, q.k} == (val_f - 16'd1));

  // Frame length and byte count must agree with the function code.
  always_comb begin
    need_bc = 16'h0000;
    len_ok = 1'b0;
    if (func == `MBW_FC_COIL1 || func == `MBW_FC_REG1) begin
      len_ok = (q.idx == `MBW_SINGLE_LEN);
    end else if (func == `MBW_FC_COILN || func == `MBW_FC_REGN) begin
      if (func == `MBW_FC_COILN) begin
        need_bc = (val_f + 16'd7) >> 3;
      end else begin
        need_bc = {val_f[14:0], 1'b0};
      end
      len_ok = (val_f != 16'h0000) && ({8'h00, bc_f} == need_bc) &&
               ({8'h00, q.idx} == (`MBW_MULTI_FIX + {8'h00, bc_f}));
    end
  end

  // A residual of zero over the whole frame, CRC included, means the CRC is good.
  assign frame_ok = !q.ovf && (q.crc == 16'h0000) && (q.fb[`MBW_POS_STN] == own_addr) && len_ok;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.done = 1'b0;
    bi = 8'h00;
    bj = 8'h00;
    unique case (q.st)
      DEV_RX: begin
        if (link.req_valid) begin
          if (q.idx < 8'(`MBW_FB_BYTES)) begin
            d.fb[q.idx[4:0]] = link.req_data;
          end else begin
            d.ovf = 1'b1;
          end
          if (q.idx != 8'hFF) begin
            d.idx = q.idx + 8'd1;
          end
          d.crc = mbw_crc_next(q.crc, link.req_data);
          if (link.req_last) begin
            d.st = DEV_CHK;
          end
        end
      end
      DEV_CHK: begin
        d.k = 8'h00;
        d.tidx = 4'h0;
        d.crc = `MBW_CRC_INIT;
        if (frame_ok) begin
          d.st = DEV_APPLY;
        end else begin
          // Frames for another station or with a bad CRC are dropped silently.
          d.st = DEV_RX;
          d.idx = 8'h00;
          d.ovf = 1'b0;
        end
      end
      DEV_APPLY: begin
        d.st = DEV_TX;
        case (func)
          `MBW_FC_COIL1: begin
            if (addr_f < 16'(`MBW_NCOIL)) begin
              if (val_f == `MBW_COIL_ON) begin
                d.coil[addr_f[`MBW_COIL_AW-1:0]] = 1'b1;
              end else if (val_f == `MBW_COIL_OFF) begin
                d.coil[addr_f[`MBW_COIL_AW-1:0]] = 1'b0;
              end
            end
          end
          `MBW_FC_REG1: begin
            if (addr_f < 16'(`MBW_NREG)) begin
              d.hreg[addr_f[`MBW_REG_AW-1:0]] = val_f;
            end
          end
          `MBW_FC_COILN: begin
            // One coil per cycle; byte k/8, bit k%8 with the low bit first.
            bi = `MBW_POS_DATA + {3'b000, q.k[7:3]};
            if (elem < 16'(`MBW_NCOIL)) begin
              d.coil[elem[`MBW_COIL_AW-1:0]] = q.fb[bi[4:0]][q.k[2:0]];
            end
            d.k = q.k + 8'd1;
            if (!apply_last) begin
              d.st = DEV_APPLY;
            end
          end
          `MBW_FC_REGN: begin
            // One register per cycle, high byte first, ascending addresses.
            bi = `MBW_POS_DATA + {q.k[6:0], 1'b0};
            bj = bi + 8'd1;
            if (elem < 16'(`MBW_NREG)) begin
              d.hreg[elem[`MBW_REG_AW-1:0]] = {q.fb[bi[4:0]], q.fb[bj[4:0]]};
            end
            d.k = q.k + 8'd1;
            if (!apply_last) begin
              d.st = DEV_APPLY;
            end
          end
          default: begin
            d.st = DEV_TX;
          end
        endcase
      end
      DEV_TX: begin
        // The first six request bytes go back followed by a fresh CRC; for the
        // single writes this equals the received CRC, so the answer is an echo.
        if (link.rsp_ready) begin
          if (q.tidx < `MBW_RSP_BODY) begin
            d.crc = mbw_crc_next(q.crc, q.fb[{1'b0, q.tidx}]);
          end
          d.tidx = q.tidx + 4'h1;
          if (q.tidx == `MBW_RSP_LEN - 4'h1) begin
            d.st = DEV_RX;
            d.idx = 8'h00;
            d.ovf = 1'b0;
            d.crc = `MBW_CRC_INIT;
            d.done = 1'b1;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= DEV_RX;
      q.crc <= `MBW_CRC_INIT;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign link.req_ready = (q.st == DEV_RX);
  assign link.rsp_valid = (q.st == DEV_TX);
  assign link.rsp_last = (q.st == DEV_TX) && (q.tidx == `MBW_RSP_LEN - 4'h1);

  always_comb begin
    if (q.tidx < `MBW_RSP_BODY) begin
      link.rsp_data = q.fb[{1'b0, q.tidx}];
    end else if (q.tidx == `MBW_RSP_BODY) begin
      link.rsp_data = q.crc[7:0];
    end else begin
      link.rsp_data = q.crc[15:8];
    end
  end

  assign coil_area = q.coil;
  assign holding_register_area = q.hreg;
  assign wr_done = q.done;

endmodule
`default_nettype wire

// ### rtl/mbw_params.svh
// Constants shared by both ends of the serial write link.
`ifndef MBW_PARAMS_SVH
`define MBW_PARAMS_SVH
// ==========================================================
// Function codes and coil force values
`define MBW_FC_COIL1 8'h05
`define MBW_FC_REG1 8'h06
`define MBW_FC_COILN 8'h0F
`define MBW_FC_REGN 8'h10
`define MBW_COIL_ON 16'hFF00
`define MBW_COIL_OFF 16'h0000
// ==========================================================
// Frame byte positions and lengths
`define MBW_POS_STN 5'd0
`define MBW_POS_FUNC 5'd1
`define MBW_POS_AHI 5'd2
`define MBW_POS_ALO 5'd3
`define MBW_POS_VHI 5'd4
`define MBW_POS_VLO 5'd5
`define MBW_POS_BC 5'd6
`define MBW_POS_DATA 8'd7
`define MBW_SINGLE_LEN 8'd8
`define MBW_MULTI_FIX 16'd9
`define MBW_RSP_BODY 4'd6
`define MBW_RSP_LEN 4'd8
`define MBW_PAYLOAD_MAX 16
// ==========================================================
// Storage sizes
`define MBW_FB_BYTES 32
`define MBW_NCOIL 64
`define MBW_COIL_AW 6
`define MBW_NREG 16
`define MBW_REG_AW 4
// ==========================================================
// Checksum and timing
`define MBW_CRC_INIT 16'hFFFF
`define MBW_CRC_POLY 16'hA001
`define MBW_CLK_MHZ 250
`define MBW_RSP_TIMEOUT_US 1000
`endif

// ### rtl/mbw_pkg.sv
// Types and checksum function shared by both ends.
`include "mbw_params.svh"
package mbw_pkg;
  // ==========================================================
  // State encodings
  typedef enum logic [1:0] {
    DEV_RX = 2'b00,
    DEV_CHK = 2'b01,
    DEV_APPLY = 2'b10,
    DEV_TX = 2'b11
  } mbw_dev_st_type;

  typedef enum logic [1:0] {
    MST_IDLE = 2'b00,
    MST_SEND = 2'b01,
    MST_WAIT = 2'b10
  } mbw_mst_st_type;

  // ==========================================================
  // Frame checksum, one byte at a time, reflected polynomial.
  function automatic logic [15:0] mbw_crc_next(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      if (r[0]) begin
        r = (r >> 1) ^ `MBW_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction
endpackage

// ### rtl/mbw_link_if.sv
// Byte-stream link between the master end and the write-handling slave end.
`timescale 1ns/1ns
`default_nettype none
interface mbw_link_if;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_data;
  logic req_last;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_last;

  modport dev (
    input req_valid, req_data, req_last, rsp_ready,
    output req_ready, rsp_valid, rsp_data, rsp_last
  );

  modport mst (
    output req_valid, req_data, req_last, rsp_ready,
    input req_ready, rsp_valid, rsp_data, rsp_last
  );
endinterface
`default_nettype wire

// ### rtl/mbw_write_master.sv
// Master end: frames write commands, sends them, checks the answer.
`timescale 1ns/1ns
`default_nettype none
`include "mbw_params.svh"
module mbw_write_master
  import mbw_pkg::*;
#(
  parameter int unsigned RSP_TIMEOUT_CYC = `MBW_RSP_TIMEOUT_US * `MBW_CLK_MHZ
)
(
  input wire logic core_clk,
  input wire logic rst,
  mbw_link_if.mst link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_station,
  input wire logic [7:0] cmd_func,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_word,
  input wire logic [127:0] cmd_data,
  output logic rsp_done,
  output logic rsp_ok
);

  // ==========================================================
  // State
  typedef struct packed {
    mbw_mst_st_type st;
    logic [`MBW_FB_BYTES-1:0][7:0] fb;
    logic [7:0] len;
    logic [7:0] idx;
    logic [15:0] crc;
    logic [3:0] ridx;
    logic mism;
    logic [19:0] tmo;
    logic done;
    logic ok;
  } mbw_mst_state_type;

  mbw_mst_state_type q;
  mbw_mst_state_type d;
  logic multi;
  logic [7:0] bc;
  logic [7:0] pbyte;
  logic [15:0] crc_n;

  assign multi = (cmd_func == `MBW_FC_COILN) || (cmd_func == `MBW_FC_REGN);
  assign crc_n = mbw_crc_next(q.crc, link.rsp_data);

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.done = 1'b0;
    bc = 8'h00;
    pbyte = 8'h00;
    unique case (q.st)
      MST_IDLE: begin
        if (cmd_valid) begin
          if (cmd_func == `MBW_FC_COILN) begin
            bc = 8'((cmd_word + 16'd7) >> 3);
          end else if (cmd_func == `MBW_FC_REGN) begin
            bc = {cmd_word[6:0], 1'b0};
          end
          d.fb = '0;
          d.fb[`MBW_POS_STN] = cmd_station;
          d.fb[`MBW_POS_FUNC] = cmd_func;
          d.fb[`MBW_POS_AHI] = cmd_addr[15:8];
          d.fb[`MBW_POS_ALO] = cmd_addr[7:0];
          if (cmd_func == `MBW_FC_COIL1) begin
            d.fb[`MBW_POS_VHI] = (cmd_word != 16'h0000) ? 8'(`MBW_COIL_ON >> 8) : 8'h00;
            d.fb[`MBW_POS_VLO] = 8'h00;
          end else begin
            d.fb[`MBW_POS_VHI] = cmd_word[15:8];
            d.fb[`MBW_POS_VLO] = cmd_word[7:0];
          end
          d.fb[`MBW_POS_BC] = bc;
          for (int j = 0; j < `MBW_PAYLOAD_MAX; j++) begin
            for (int b = 0; b < 8; b++) begin
              if (cmd_func == `MBW_FC_COILN) begin
                pbyte[b] = cmd_data[j*8+b] & ((j*8+b) < int'(cmd_word));
              end else begin
                pbyte[b] = cmd_data[(j^1)*8+b];
              end
            end
            if (multi) begin
              d.fb[7+j] = pbyte;
            end
          end
          d.len = multi ? (`MBW_POS_DATA + bc) : 8'd6;
          d.idx = 8'h00;
          d.crc = `MBW_CRC_INIT;
          d.st = MST_SEND;
        end
      end
      MST_SEND: begin
        if (link.req_ready) begin
          if (q.idx < q.len) begin
            d.crc = mbw_crc_next(q.crc, q.fb[q.idx[4:0]]);
          end
          d.idx = q.idx + 8'd1;
          if (q.idx == q.len + 8'd1) begin
            d.st = MST_WAIT;
            d.crc = `MBW_CRC_INIT;
            d.ridx = 4'h0;
            d.mism = 1'b0;
            d.tmo = 20'h00000;
          end
        end
      end
      MST_WAIT: begin
        d.tmo = q.tmo + 20'h00001;
        if (link.rsp_valid) begin
          d.crc = crc_n;
          if (q.ridx != 4'hF) begin
            d.ridx = q.ridx + 4'h1;
          end
          if (q.ridx < `MBW_RSP_BODY && link.rsp_data != q.fb[{1'b0, q.ridx}]) begin
            d.mism = 1'b1;
          end
          if (link.rsp_last) begin
            d.st = MST_IDLE;
            d.done = 1'b1;
            d.ok = !d.mism && (crc_n == 16'h0000) && (q.ridx == `MBW_RSP_LEN - 4'h1);
          end
        end else if (q.tmo == 20'(RSP_TIMEOUT_CYC - 1)) begin
          d.st = MST_IDLE;
          d.done = 1'b1;
          d.ok = 1'b0;
        end
      end
      default: begin
        d.st = MST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= MST_IDLE;
      q.crc <= `MBW_CRC_INIT;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign cmd_ready = (q.st == MST_IDLE);
  assign link.req_valid = (q.st == MST_SEND);
  assign link.req_last = (q.st == MST_SEND) && (q.idx == q.len + 8'd1);
  assign link.rsp_ready = (q.st == MST_WAIT);

  always_comb begin
    if (q.idx < q.len) begin
      link.req_data = q.fb[q.idx[4:0]];
    end else if (q.idx == q.len) begin
      link.req_data = q.crc[7:0];
    end else begin
      link.req_data = q.crc[15:8];
    end
  end

  assign rsp_done = q.done;
  assign rsp_ok = q.ok;

endmodule
`default_nettype wire

// ### test/mbw_link_monitor.sv
// Checker on the request and answer byte link between the two ends.
`timescale 1ns/1ns
`default_nettype none
module mbw_link_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  logic req_take;
  logic rsp_take;
  logic [4:0] ri_q;
  logic [3:0] si_q;
  logic [7:0] stn_q;
  logic [7:0] fc_q;
  logic [7:0] bc_q;
  assign req_take = req_valid && req_ready;
  assign rsp_take = rsp_valid && rsp_ready;
  // ==========
  // Byte positions within the current request and answer.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ri_q <= 5'h00;
      si_q <= 4'h0;
      stn_q <= 8'h00;
      fc_q <= 8'h00;
      bc_q <= 8'h00;
    end else begin
      if (req_take) begin
        ri_q <= req_last ? 5'h00 : ri_q + 5'h01;
        if (ri_q == 5'h00) stn_q <= req_data;
        if (ri_q == 5'h01) fc_q <= req_data;
        if (ri_q == 5'h06) bc_q <= req_data;
      end
      if (rsp_take) si_q <= rsp_last ? 4'h0 : si_q + 4'h1;
    end
  end
  // ==========
  // Link properties.
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence req_end;
    req_take && req_last;
  endsequence
  sequence rsp_beat;
    rsp_valid && rsp_ready;
  endsequence
  sequence rsp_wait;
    rsp_valid && !rsp_ready;
  endsequence
  req_hold_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data) && $stable(req_last))
    else $error("request byte changed before it was taken");
  rsp_hold_a: assert property (rsp_wait |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
    else $error("answer byte changed before it was taken");
  rx_refuse_a: assert property (req_end |=> !req_ready [*2])
    else $error("slave took bytes right after a frame end");
  answer_due_a: assert property (req_end |-> ##[2:40] rsp_valid)
    else $error("no answer after a request");
  quiet_rx_a: assert property (rsp_valid |-> !req_ready)
    else $error("slave receiving while answering");
  rsp_len_a: assert property (rsp_beat ##0 rsp_last |-> si_q == 4'h7)
    else $error("answer is not eight bytes");
  single_len_a: assert property (req_end ##0 (fc_q == 8'h05 || fc_q == 8'h06) |-> ri_q == 5'h07)
    else $error("single write request is not eight bytes");
  multi_len_a: assert property (req_end ##0 (fc_q == 8'h0F || fc_q == 8'h10) |-> ri_q == bc_q[4:0] + 5'h08)
    else $error("multiple write request length disagrees with byte count");
  stn_echo_a: assert property (rsp_beat ##0 (si_q == 4'h0) |-> rsp_data == stn_q)
    else $error("answer station byte differs");
  fc_echo_a: assert property (rsp_beat ##0 (si_q == 4'h1) |-> rsp_data == fc_q)
    else $error("answer function byte differs");
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Bench for the write master and write slave joined by the byte link.
`timescale 1ns/1ns
`default_nettype none
`include "mbw_params.svh"
module tb_top;
  logic core_clk;
  logic rst;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_func;
  logic [15:0] cmd_addr;
  logic [15:0] cmd_word;
  logic [127:0] cmd_data;
  logic rsp_done;
  logic rsp_ok;
  logic wr_done;
  logic [63:0] coils;
  logic [63:0] coils2;
  logic [255:0] regs;
  logic [7:0] e[$];
  logic [7:0] x[$];
  logic [7:0] qq[$];
  logic [7:0] rq[$];
  int err_count = 0;
  int comparisons = 0;
  mbw_link_if link();
  mbw_link_if link2();
  mbw_write_master #(.RSP_TIMEOUT_CYC(200)) i_mbw_write_master (.core_clk(core_clk), .rst(rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_station(8'h11), .cmd_func(cmd_func), .cmd_addr(cmd_addr),
    .cmd_word(cmd_word), .cmd_data(cmd_data), .rsp_done(rsp_done), .rsp_ok(rsp_ok));
  mbw_write_slave i_mbw_write_slave (.core_clk(core_clk), .rst(rst), .link(link), .own_addr(8'h11),
    .coil_area(coils), .holding_register_area(regs), .wr_done(wr_done));
  mbw_write_slave i_mbw_write_slave_2 (.core_clk(core_clk), .rst(rst), .link(link2), .own_addr(8'h22),
    .coil_area(coils2), .holding_register_area(), .wr_done());
  mbw_link_monitor i_mbw_link_monitor (.core_clk(core_clk), .rst(rst), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_data(link.req_data), .req_last(link.req_last), .rsp_valid(link.rsp_valid),
    .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data), .rsp_last(link.rsp_last));
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
  always @(posedge core_clk) begin
    if (link.req_valid && link.req_ready) qq.push_back(link.req_data);
    if (link.rsp_valid && link.rsp_ready) rq.push_back(link.rsp_data);
    if (link2.rsp_valid && link2.rsp_ready) rq.push_back(link2.rsp_data);
  end
  // ==========
  // Checksum, expected frames and comparisons.
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `MBW_CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ `MBW_CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic mk(input logic [7:0] st, input logic [7:0] fc, input logic [15:0] a, input logic [15:0] w,
                    input logic [127:0] d);
    logic [15:0] c;
    int n;
    e = {st, fc, a[15:8], a[7:0]};
    if (fc == `MBW_FC_COIL1) w = (w != 0) ? `MBW_COIL_ON : `MBW_COIL_OFF;
    e.push_back(w[15:8]);
    e.push_back(w[7:0]);
    x = e;
    if (fc == `MBW_FC_COILN || fc == `MBW_FC_REGN) begin
      n = (fc == `MBW_FC_COILN) ? (w + 7) / 8 : 2 * w;
      e.push_back(n[7:0]);
      for (int k = 0; k < n; k++) e.push_back(fc == `MBW_FC_COILN ? d[8*k+:8] : d[16*(k/2)+8*(1-k%2)+:8]);
    end
    c = crc(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    c = crc(x);
    x.push_back(c[7:0]);
    x.push_back(c[15:8]);
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] v);
    comparisons++;
    if (g !== v) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, v);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] v);
    chk_word({8'h00, g}, {8'h00, v});
  endtask
  task automatic chk_bit(input logic g, input logic v);
    chk_word({15'h0000, g}, {15'h0000, v});
  endtask
  // ==========
  // Master command on the main link, raw frame on the second link.
  task automatic cmd(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] w, input logic [127:0] d);
    int t;
    mk(8'h11, fc, a, w, d);
    qq = {};
    rq = {};
    @(posedge core_clk);
    #1;
    cmd_func = fc;
    cmd_addr = a;
    cmd_word = w;
    cmd_data = d;
    cmd_valid = 1;
    while (cmd_ready !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 0;
    t = 0;
    while (rsp_done !== 1'b1 && t < 500) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    chk_bit(rsp_done && rsp_ok && wr_done, 1'b1);
    foreach (e[i]) chk_byte(qq[i], e[i]);
    foreach (x[i]) chk_byte(rq[i], x[i]);
  endtask
  task automatic s2(input logic [7:0] st, input logic bad, input int n);
    mk(st, `MBW_FC_COIL1, 16'h0004, 16'h0001, 128'h0);
    if (bad) e[6] = ~e[6];
    rq = {};
    @(posedge core_clk);
    #1;
    foreach (e[i]) begin
      link2.req_valid = 1;
      link2.req_data = e[i];
      link2.req_last = (i == e.size() - 1);
      do @(posedge core_clk); while (link2.req_ready !== 1'b1);
      #1;
    end
    link2.req_valid = 0;
    link2.req_last = 0;
    link2.req_data = ~link2.req_data;
    repeat (60) @(posedge core_clk);
    chk_byte(8'(rq.size()), 8'(n));
    for (int i = 0; i < n; i++) chk_byte(rq[i], x[i]);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========
  // Tests.
  initial begin
    rst = 1;
    cmd_valid = 0;
    cmd_func = 8'h00;
    cmd_addr = 16'h0000;
    cmd_word = 16'h0000;
    cmd_data = 128'h0;
    link2.req_valid = 0;
    link2.req_data = 8'h00;
    link2.req_last = 0;
    link2.rsp_ready = 1;
    repeat (4) @(posedge core_clk);
    #1 rst = 0;
    cmd(`MBW_FC_COIL1, 16'h000A, 16'h0001, 128'h0);
    cmd(`MBW_FC_COIL1, 16'h0003, 16'h0001, 128'h0);
    cmd(`MBW_FC_COIL1, 16'h0003, 16'h0000, 128'h0);
    chk_bit(coils[10], 1'b1);
    chk_bit(coils[3], 1'b0);
    $display("test single coil done");
    cmd(`MBW_FC_COILN, 16'h0000, 16'h000A, 128'h2CD);
    chk_word(coils[15:0], 16'h06CD);
    $display("test multiple coils done");
    cmd(`MBW_FC_REG1, 16'h000F, 16'h039E, 128'h0);
    chk_word(regs[255:240], 16'h039E);
    $display("test single register done");
    cmd(`MBW_FC_REGN, 16'h0007, 16'h0002, 128'h0A10_0105);
    chk_word(regs[127:112], 16'h0105);
    chk_word(regs[143:128], 16'h0A10);
    chk_word(regs[159:144], 16'h0000);
    $display("test multiple registers done");
    s2(8'h22, 1'b1, 0);
    s2(8'h33, 1'b0, 0);
    chk_bit(coils2[4], 1'b0);
    s2(8'h22, 1'b0, 8);
    chk_bit(coils2[4], 1'b1);
    $display("test station and checksum done");
    results();
  end
endmodule
`default_nettype wire
